// file: rtl/avs_ai_chan.sv
/*
  avs_ai_chan: one analog input channel; range check and value register.
  Assumes samples already in the counts of the active mode, and a sense
  voltage in voltage counts from the front end, both synchronous.
*/
`timescale 1ns/1ps
module avs_ai_chan #(
  parameter logic [3:0] GAIN_TEMP = avs_pkg::AVS_GAIN_TEMP
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire avs_pkg::avs_ai_mode_t mode_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sense_i,
  output logic [3:0] gain_o,
  output avs_pkg::avs_ai_res_t res_o
);
  logic [15:0] value;
  logic [15:0] next_value;
  logic [3:0] next_gain;
  logic signed [15:0] hi;
  logic signed [15:0] lo;
  logic ovf;
  logic open_hit;
  logic neg;

  // band limits per mode, compared as signed words
  always_comb begin
    hi = avs_pkg::AVS_AI_V_OVR;
    lo = avs_pkg::AVS_AI_V_UNR;
    unique case (mode_i)
      avs_pkg::AVS_AI_CURR: begin
        hi = avs_pkg::AVS_AI_I_OVR;
        lo = avs_pkg::AVS_AI_I_UNR;
      end
      avs_pkg::AVS_AI_TEMP: begin
        hi = avs_pkg::AVS_AI_T_MAX;
        lo = avs_pkg::AVS_AI_T_MIN;
      end
      avs_pkg::AVS_AI_OFF, avs_pkg::AVS_AI_VOLT: begin
      end
    endcase
  end

  // events only while sampling in an active mode
  assign ovf = sample_valid_i && (mode_i != avs_pkg::AVS_AI_OFF)
    && (($signed(sample_i) > hi) || ($signed(sample_i) < lo));
  assign open_hit = sample_valid_i && (mode_i == avs_pkg::AVS_AI_TEMP)
    && ($signed(sense_i) > avs_pkg::AVS_OPEN_THR);
  assign neg = sample_valid_i && (mode_i == avs_pkg::AVS_AI_TEMP)
    && !open_hit && sense_i[15];

  // bad readings show zero rather than a stale value
  always_comb begin
    next_value = value;
    if (mode_i == avs_pkg::AVS_AI_OFF) begin
      next_value = 16'h0000;
    end else if (sample_valid_i) begin
      next_value = (ovf || open_hit) ? 16'h0000 : sample_i;
    end
    next_gain = (mode_i == avs_pkg::AVS_AI_TEMP) ? GAIN_TEMP : avs_pkg::AVS_GAIN_ONE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      value <= 16'h0000;
      gain_o <= avs_pkg::AVS_GAIN_ONE;
    end else begin
      value <= next_value;
      gain_o <= next_gain;
    end
  end

  assign res_o = '{value: value, ovf: ovf, open_hit: open_hit, neg: neg};
endmodule // avs_ai_chan

// file: rtl/avs_ao_chan.sv
/*
  avs_ao_chan: one analog output channel; range check and converter code.
  Assumes the converter takes the signed word unchanged, one per clock.
*/
`timescale 1ns/1ps
module avs_ao_chan (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire avs_pkg::avs_ao_mode_t mode_i,
  input wire logic [15:0] word_i,
  output avs_pkg::avs_ao_res_t res_o
);
  logic [15:0] code;
  logic [15:0] next_code;
  logic signed [15:0] hi;
  logic signed [15:0] lo;
  logic active;
  logic ovf;

  // voltage and current share code points, not band ends
  assign hi = (mode_i == avs_pkg::AVS_AO_CURR) ? avs_pkg::AVS_AO_I_OVR
    : avs_pkg::AVS_AO_V_OVR;
  assign lo = (mode_i == avs_pkg::AVS_AO_CURR) ? avs_pkg::AVS_AO_I_UNR
    : avs_pkg::AVS_AO_V_UNR;
  assign active = (mode_i == avs_pkg::AVS_AO_VOLT) || (mode_i == avs_pkg::AVS_AO_CURR);
  assign ovf = active && (($signed(word_i) > hi) || ($signed(word_i) < lo));

  // inactive or out of band drives zero
  always_comb begin
    next_code = (active && !ovf) ? word_i : 16'h0000;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      code <= 16'h0000;
    end else begin
      code <= next_code;
    end
  end

  assign res_o = '{code: code, ovf: ovf, bad: (mode_i == avs_pkg::AVS_AO_BAD)};
endmodule // avs_ao_chan

// file: rtl/avs_pkg.sv
/*
  avs_pkg: shared constants and types of the analog value scaling block
  (register offsets, mode codes, code points, band limits, diagnostic codes).
  Assumes one 250 MHz clock domain and an AXI4-Lite register bus.
*/
package avs_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam int unsigned AVS_ADDR_W = 8;
  localparam logic [7:0] AVS_OFS_CTRL = 8'h00;
  localparam logic [7:0] AVS_OFS_STAT = 8'h04;
  localparam logic [7:0] AVS_OFS_AI0 = 8'h08;
  localparam logic [7:0] AVS_OFS_AI1 = 8'h0C;
  localparam logic [7:0] AVS_OFS_AO0 = 8'h10;
  localparam logic [7:0] AVS_OFS_AO1 = 8'h14;
  localparam logic [7:0] AVS_OFS_DIAG = 8'h18;

  localparam logic [1:0] AVS_RESP_OKAY = 2'h0;
  localparam logic [1:0] AVS_RESP_SLVERR = 2'h2;

  // field positions and reset values
  localparam int unsigned AVS_FMT_BIT = 0;
  localparam int unsigned AVS_ERR_BIT = 7;
  localparam logic [7:0] AVS_CTRL_RST = 8'h00;
  localparam logic [3:0] AVS_GAIN_ONE = 4'h1;
  localparam logic [3:0] AVS_GAIN_TEMP = 4'h8;

  // channel modes
  typedef enum logic [1:0] {
    AVS_AI_OFF = 2'b00,
    AVS_AI_VOLT = 2'b01,
    AVS_AI_CURR = 2'b10,
    AVS_AI_TEMP = 2'b11
  } avs_ai_mode_t;

  typedef enum logic [1:0] {
    AVS_AO_OFF = 2'b00,
    AVS_AO_VOLT = 2'b01,
    AVS_AO_CURR = 2'b10,
    AVS_AO_BAD = 2'b11
  } avs_ao_mode_t;

  // weight of one count: volts, milliamperes, degrees
  localparam real AVS_AI_V_LSB = 0.00151947;
  localparam real AVS_AI_I_LSB = 0.003051758;
  localparam real AVS_AI_T_LSB = 0.1;
  localparam real AVS_AO_V_LSB = 0.000381469;
  localparam real AVS_AO_I_LSB = 0.0007629;

  // nominal full-scale code points
  localparam logic signed [15:0] AVS_AI_V_POS = 16'h19B5;
  localparam logic signed [15:0] AVS_AI_V_NEG = 16'hE64B;
  localparam logic signed [15:0] AVS_AI_I_POS = 16'h1999;
  localparam logic signed [15:0] AVS_AI_I_NEG = 16'hE666;
  localparam logic signed [15:0] AVS_AI_T_MAX = 16'h0A28;
  localparam logic signed [15:0] AVS_AI_T_MIN = 16'hF830;
  localparam logic signed [15:0] AVS_AO_POS = 16'h6666;
  localparam logic signed [15:0] AVS_AO_NEG = 16'h999A;

  // end of the over/underrange bands: 11.75 V, 23.5 mA, 10.5 V, 20.2 mA
  localparam logic signed [15:0] AVS_AI_V_OVR = 16'h1E34;
  localparam logic signed [15:0] AVS_AI_V_UNR = 16'hE1CC;
  localparam logic signed [15:0] AVS_AI_I_OVR = 16'h1E14;
  localparam logic signed [15:0] AVS_AI_I_UNR = 16'hE1EC;
  localparam logic signed [15:0] AVS_AO_V_OVR = 16'h6B85;
  localparam logic signed [15:0] AVS_AO_V_UNR = 16'h947B;
  localparam logic signed [15:0] AVS_AO_I_OVR = 16'h676D;
  localparam logic signed [15:0] AVS_AO_I_UNR = 16'h9893;

  // open sensor threshold 0.25 V in voltage counts
  localparam logic signed [15:0] AVS_OPEN_THR = 16'h00A4;

  // diagnostics slot
  localparam logic [7:0] AVS_DIAG_CNT = 8'h02;
  localparam logic [7:0] AVS_DIAG_MODE = 8'h03;
  localparam logic [7:0] AVS_DIAG_OPEN = 8'h06;
  localparam logic [7:0] AVS_DIAG_OVF = 8'h07;

  typedef struct packed {
    logic [15:0] value;
    logic ovf;
    logic open_hit;
    logic neg;
  } avs_ai_res_t;

  typedef struct packed {
    logic [15:0] code;
    logic ovf;
    logic bad;
  } avs_ao_res_t;

endpackage

// file: rtl/avs_top.sv
/*
  avs_top: analog value scaling block with AXI4-Lite registers, two input
  and two output channels, mode echo, fallback and diagnostics.
  Assumes synchronous front-end inputs and one clock at 250 MHz.
*/
// Decided for this implementation: register access over AXI4-Lite and the address map.
// What this block does
// - channel values are signed 16-bit counts times a mode weight.
// - voltage input: 0x19B5 is +10 V, 0xE64B is -10 V.
// - current input: 0x1999 is +20 mA, 0xE666 is -20 mA.
// - temperature input: tenths of a degree, 0xF830 up to 0x0A28.
// - voltage output: 0x6666 drives +10 V, 0x999A drives -10 V.
// - current output: 0x6666 drives +20 mA, 0x999A drives -20 mA.
// - open sensor in temperature mode falls back to inactive, gain one.
// - fallback shows per channel in status byte zero.
// - fallback posts an error code in diagnostics with counter two.
// - slightly negative open input raises module error status.
// - input mode field: off, voltage, current, temperature.
// - output mode field: off, voltage, current, illegal.
// - status byte zero echoes modes in force; mismatch means error.
`timescale 1ns/1ps
module avs_top #(
  parameter logic [3:0] GAIN_TEMP = avs_pkg::AVS_GAIN_TEMP
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0][15:0] ai_sample_i,
  input wire logic [1:0] ai_sample_valid_i,
  input wire logic [1:0][15:0] ai_sense_i,
  output logic [1:0][3:0] ai_gain_o,
  output logic [1:0][1:0] ai_mode_o,
  output logic [1:0][15:0] ao_code_o,
  output logic [1:0][1:0] ao_mode_o,
  output logic bus_fault_indicator_o
);
  // bus state
  logic aw_full, next_aw_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_full, next_w_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_go, wr_ok, wr_ctrl0, wr_fmt;
  logic [1:0] wr_ao;

  // control state
  logic [7:0] ctrl0, next_ctrl0;
  logic fmt, next_fmt;
  logic [1:0][15:0] ao_word, next_ao_word;
  logic [3:0] deact, next_deact;
  logic neg_err, next_neg_err;
  logic [7:0] diag_cnt, next_diag_cnt;
  logic [7:0] diag_code, next_diag_code;

  logic [3:0] ev;
  logic open_any, ovf_any, neg_any, bad_any, err;
  logic [7:0] stat0, stat1;
  avs_pkg::avs_ai_mode_t ai_eff [2];
  avs_pkg::avs_ao_mode_t ao_eff [2];
  avs_pkg::avs_ai_res_t ai_res [2];
  avs_pkg::avs_ao_res_t ao_res [2];

  // channels; a deactivated channel runs as inactive until the mode is rewritten
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign ai_eff[i] = deact[i] ? avs_pkg::AVS_AI_OFF
      : avs_pkg::avs_ai_mode_t'(ctrl0[2*i +: 2]);
    assign ao_eff[i] = deact[2+i] ? avs_pkg::AVS_AO_OFF
      : avs_pkg::avs_ao_mode_t'(ctrl0[4+2*i +: 2]);
    assign ai_mode_o[i] = ai_eff[i];
    assign ao_mode_o[i] = ao_res[i].bad ? 2'b00 : ao_eff[i];
    assign ao_code_o[i] = ao_res[i].code;
    assign ev[i] = ai_res[i].ovf || ai_res[i].open_hit;
    assign ev[2+i] = ao_res[i].ovf;

    avs_ai_chan #(
      .GAIN_TEMP(GAIN_TEMP)
    ) u_ai (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .mode_i(ai_eff[i]),
      .sample_i(ai_sample_i[i]),
      .sample_valid_i(ai_sample_valid_i[i]),
      .sense_i(ai_sense_i[i]),
      .gain_o(ai_gain_o[i]),
      .res_o(ai_res[i])
    );

    avs_ao_chan u_ao (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .mode_i(ao_eff[i]),
      .word_i(ao_word[i]),
      .res_o(ao_res[i])
    );
  end

  // summary flags and status bytes
  assign open_any = ai_res[0].open_hit || ai_res[1].open_hit;
  assign ovf_any = ai_res[0].ovf || ai_res[1].ovf || ao_res[0].ovf || ao_res[1].ovf;
  assign neg_any = ai_res[0].neg || ai_res[1].neg;
  assign bad_any = ao_res[0].bad || ao_res[1].bad;
  assign err = (|deact) || neg_err || bad_any;
  assign stat0 = {ao_mode_o, ai_eff[1], ai_eff[0]};
  assign stat1 = {err, 6'h00, fmt};
  assign bus_fault_indicator_o = err;

  // write decode; control bytes may go byte by byte, values only with both low byte strobes
  assign wr_go = aw_full && w_full && !bvalid;
  assign wr_ctrl0 = wr_go && (aw_addr == avs_pkg::AVS_OFS_CTRL) && w_strb[0];
  assign wr_fmt = wr_go && (aw_addr == avs_pkg::AVS_OFS_CTRL) && w_strb[1];
  assign wr_ao[0] = wr_go && (aw_addr == avs_pkg::AVS_OFS_AO0) && (w_strb[1:0] == 2'b11);
  assign wr_ao[1] = wr_go && (aw_addr == avs_pkg::AVS_OFS_AO1) && (w_strb[1:0] == 2'b11);
  assign wr_ok = (aw_addr == avs_pkg::AVS_OFS_CTRL) || (|wr_ao);

  // read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      avs_pkg::AVS_OFS_CTRL: rd_mux = {23'h00_0000, fmt, ctrl0};
      avs_pkg::AVS_OFS_STAT: rd_mux = {16'h0000, stat1, stat0};
      avs_pkg::AVS_OFS_AI0: rd_mux = {16'h0000, ai_res[0].value};
      avs_pkg::AVS_OFS_AI1: rd_mux = {16'h0000, ai_res[1].value};
      avs_pkg::AVS_OFS_AO0: rd_mux = {16'h0000, ao_word[0]};
      avs_pkg::AVS_OFS_AO1: rd_mux = {16'h0000, ao_word[1]};
      avs_pkg::AVS_OFS_DIAG: rd_mux = {16'h0000, diag_code, diag_cnt};
      default: rd_ok = 1'b0;
    endcase
  end

  // bus handshakes; one write and one read in flight
  assign s_axi_awready_o = !aw_full && !bvalid;
  assign s_axi_wready_o = !w_full && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? avs_pkg::AVS_RESP_OKAY : avs_pkg::AVS_RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = rd_ok ? avs_pkg::AVS_RESP_OKAY : avs_pkg::AVS_RESP_SLVERR;
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= avs_pkg::AVS_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= avs_pkg::AVS_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // control, deactivation and diagnostics; a new event beats a clearing write
  always_comb begin
    next_ctrl0 = wr_ctrl0 ? w_data[7:0] : ctrl0;
    next_fmt = wr_fmt ? w_data[8 + avs_pkg::AVS_FMT_BIT] : fmt;
    next_ao_word = ao_word;
    for (int j = 0; j < 2; j++) begin
      if (wr_ao[j]) begin
        next_ao_word[j] = w_data[15:0];
      end
    end
    next_deact = ev | (deact & ~{4{wr_ctrl0}});
    next_neg_err = neg_any || (neg_err && !wr_ctrl0);
    next_diag_cnt = diag_cnt;
    next_diag_code = diag_code;
    if (open_any) begin
      next_diag_cnt = avs_pkg::AVS_DIAG_CNT;
      next_diag_code = avs_pkg::AVS_DIAG_OPEN;
    end else if (ovf_any) begin
      next_diag_cnt = avs_pkg::AVS_DIAG_CNT;
      next_diag_code = avs_pkg::AVS_DIAG_OVF;
    end else if (bad_any) begin
      next_diag_cnt = avs_pkg::AVS_DIAG_CNT;
      next_diag_code = avs_pkg::AVS_DIAG_MODE;
    end else if (wr_ctrl0) begin
      next_diag_cnt = 8'h00;
      next_diag_code = 8'h00;
    end
  end

  // modes stay off after reset until software sets them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl0 <= avs_pkg::AVS_CTRL_RST;
      fmt <= 1'b0;
      ao_word <= '0;
      deact <= 4'h0;
      neg_err <= 1'b0;
      diag_cnt <= 8'h00;
      diag_code <= 8'h00;
    end else begin
      ctrl0 <= next_ctrl0;
      fmt <= next_fmt;
      ao_word <= next_ao_word;
      deact <= next_deact;
      neg_err <= next_neg_err;
      diag_cnt <= next_diag_cnt;
      diag_code <= next_diag_code;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  open_fallback_a: assert property (ai_res[0].open_hit |=> deact[0] && ai_mode_o[0] == 2'b00 ##1 ai_gain_o[0] == avs_pkg::AVS_GAIN_ONE)
    else $error("open sensor did not fall back");
  status_fallback_a: assert property (ai_res[0].open_hit |=> stat0[1:0] == 2'b00 && stat1[avs_pkg::AVS_ERR_BIT])
    else $error("fallback not in status");
  diag_open_a: assert property (open_any |=> diag_cnt == avs_pkg::AVS_DIAG_CNT && diag_code == avs_pkg::AVS_DIAG_OPEN)
    else $error("diagnostics not posted");
  neg_fault_a: assert property (neg_any && !wr_ctrl0 |=> bus_fault_indicator_o [*2])
    else $error("negative open input gave no fault");
  mode_echo_a: assert property (wr_ctrl0 && w_data[7:6] != 2'b11 && w_data[5:4] != 2'b11 |=> (|deact) || stat0 == ctrl0)
    else $error("status echo differs from control");
  ao_illegal_a: assert property (ctrl0[5:4] == 2'b11 |-> ao_mode_o[0] == 2'b00 ##1 ao_code_o[0] == 16'h0000)
    else $error("illegal output mode not held off");
  ai_ovf_a: assert property (ai_res[0].ovf |=> ai_res[0].value == 16'h0000 && deact[0] && err)
    else $error("input overflow not deactivated");
  ai_volt_a: assert property (ai_mode_o[0] == 2'b01 && ai_sample_valid_i[0] && ai_sample_i[0] == avs_pkg::AVS_AI_V_POS |=> ai_res[0].value == avs_pkg::AVS_AI_V_POS)
    else $error("voltage code not passed");
  ao_volt_a: assert property (ao_mode_o[1] == 2'b01 && ao_word[1] == avs_pkg::AVS_AO_NEG |=> ao_code_o[1] == avs_pkg::AVS_AO_NEG)
    else $error("output code not driven");
  ao_half_a: assert property (wr_go && aw_addr == avs_pkg::AVS_OFS_AO1 && w_strb[1:0] != 2'b11 |=> $stable(ao_word[1]) && bresp == avs_pkg::AVS_RESP_SLVERR)
    else $error("byte write changed a value");
  wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
    else $error("write answer late");

  open_seen_c: cover property (ai_res[0].open_hit ##1 wr_ctrl0);
  ao_ovf_c: cover property (ao_res[1].ovf);
  rd_ai_c: cover property (s_axi_rvalid_o && s_axi_rready_i && rdata[15:0] != 16'h0000);
  wr_done_c: cover property (s_axi_bvalid_o && s_axi_bready_i && bresp == avs_pkg::AVS_RESP_OKAY);
endmodule // avs_top

// file: testbench/avs_host_model.sv
/*
  avs_host_model: cyclic host acting as AXI4-Lite master of the block.
  Assumes one clock; every task starts one edge after it is entered.
*/
`timescale 1ns/1ps
module avs_host_model (
  input wire logic clk_sys_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // idle bus from time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // one word write; payload inverted once taken so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    {awvalid_o, wvalid_o, bready_o} <= 3'b111;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_i);
      if (!aw_ok && awready_i) begin
        aw_ok = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (!w_ok && wready_i) begin
        w_ok = 1'b1;
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end
    do @(posedge clk_sys_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  // one word read; rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr_o <= a;
    {arvalid_o, rready_o} <= 2'b11;
    do @(posedge clk_sys_i); while (!arready_i);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    do @(posedge clk_sys_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule // avs_host_model

// file: testbench/testbench.sv
/*
  testbench: directed scenarios for avs_top over its register bus and pins.
  Assumes avs_host_model as bus master and one 250 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fault;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, smp_v;
  logic [1:0][15:0] smp, sense, ao_code;
  logic [1:0][3:0] gain;
  logic [1:0][1:0] ai_mode, ao_mode;
  int fails, samples_checked;

  avs_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ai_sample_i(smp), .ai_sample_valid_i(smp_v),
    .ai_sense_i(sense), .ai_gain_o(gain), .ai_mode_o(ai_mode), .ao_code_o(ao_code),
    .ao_mode_o(ao_mode), .bus_fault_indicator_o(fault));

  avs_host_model host (.clk_sys_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  // 250 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  // write, check response, then let the register settle on the pins
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
    logic [1:0] r;
    host.wr(a, d, s, r);
    chk($sformatf("bresp %h", a), {30'h0, r}, {30'h0, e});
    repeat (2) @(posedge clk_sys_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk($sformatf("reg %h", a), d & m, e);
    chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, er});
  endtask

  task automatic ctrl(input logic [7:0] m);
    wchk(avs_pkg::AVS_OFS_CTRL, {24'h00_0001, m}, 4'h3, 2'h0);
  endtask

  task automatic fchk(input logic e);
    chk("fault", {31'h0, fault}, {31'h0, e});
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // one-cycle sample pulse on both channels, then time for the fallback
  task automatic samp(input logic [15:0] v0, input logic [15:0] v1, input logic [15:0] s);
    @(posedge clk_sys_i);
    smp <= {v1, v0};
    sense <= {s, s};
    smp_v <= 2'b11;
    @(posedge clk_sys_i);
    smp_v <= 2'b00;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic t_reset();
    rchk(avs_pkg::AVS_OFS_CTRL, '1, 32'h0000_0000, 2'h0);
    rchk(avs_pkg::AVS_OFS_STAT, '1, 32'h0000_0000, 2'h0);
    chk("gain", {24'h00_0000, gain}, 32'h0000_0011);
    chk("ao_code", ao_code, 32'h0000_0000);
    chk("modes", {24'h00_0000, ao_mode, ai_mode}, 32'h0000_0000);
    fchk(1'b0);
  endtask

  // each active input mode (voltage, current, temperature), both ends of its span, mode echo
  task automatic t_ai();
    logic [7:0] m [3] = '{8'h05, 8'h0A, 8'h0F};
    logic [15:0] p [3] = '{16'h19B5, 16'h1999, 16'h0A28};
    logic [15:0] q [3] = '{16'hE64B, 16'hE666, 16'hF830};
    for (int i = 0; i < 3; i++) begin
      ctrl(m[i]);
      samp(p[i], q[i], 16'h0000);
      rchk(avs_pkg::AVS_OFS_AI0, '1, {16'h0000, p[i]}, 2'h0);
      rchk(avs_pkg::AVS_OFS_AI1, '1, {16'h0000, q[i]}, 2'h0);
      rchk(avs_pkg::AVS_OFS_STAT, 32'h0000_00FF, {24'h00_0000, m[i]}, 2'h0);
      chk("ai_mode", {28'h000_0000, ai_mode}, {28'h000_0000, m[i][3:0]});
    end
  endtask

  task automatic t_neg();
    ctrl(8'h03);
    fchk(1'b0);
    samp(16'h0000, 16'h0000, 16'hFFFE);
    fchk(1'b1);
    chk("ai_mode", {28'h000_0000, ai_mode}, 32'h0000_0003);
  endtask

  // output modes, byte write refused, last in-band code, first out-of-band code
  task automatic t_ao();
    logic [7:0] m [2] = '{8'h50, 8'hA0};
    logic [15:0] b [2] = '{16'h6B85, 16'h676D};
    for (int i = 0; i < 2; i++) begin
      do_reset();
      ctrl(m[i]);
      wchk(avs_pkg::AVS_OFS_AO0, 32'h0000_6666, 4'hF, 2'h0);
      wchk(avs_pkg::AVS_OFS_AO1, 32'h0000_999A, 4'hF, 2'h0);
      chk("ao_code", ao_code, 32'h999A_6666);
      chk("ao_mode", {28'h000_0000, ao_mode}, {28'h000_0000, m[i][7:4]});
      wchk(avs_pkg::AVS_OFS_AO1, 32'h0000_1234, 4'h1, 2'h2);
      chk("ao_code", ao_code, 32'h999A_6666);
      wchk(avs_pkg::AVS_OFS_AO0, {16'h0000, b[i]}, 4'hF, 2'h0);
      chk("ao_code", ao_code, {16'h999A, b[i]});
      fchk(1'b0);
      wchk(avs_pkg::AVS_OFS_AO0, {16'h0000, b[i] + 16'h0001}, 4'hF, 2'h0);
      chk("ao_code", ao_code, 32'h999A_0000);
      chk("ao_mode", {28'h000_0000, ao_mode}, {28'h000_0000, m[i][7:6], 2'b00});
      fchk(1'b1);
      rchk(avs_pkg::AVS_OFS_DIAG, 32'h0000_FFFF, 32'h0000_0702, 2'h0);
    end
  endtask

  task automatic t_ai_ovf();
    do_reset();
    ctrl(8'h05);
    samp(16'h1E35, 16'hE1CC, 16'h0000);
    rchk(avs_pkg::AVS_OFS_AI0, '1, 32'h0000_0000, 2'h0);
    rchk(avs_pkg::AVS_OFS_AI1, '1, 32'h0000_E1CC, 2'h0);
    rchk(avs_pkg::AVS_OFS_STAT, 32'h0000_00FF, 32'h0000_0004, 2'h0);
    rchk(avs_pkg::AVS_OFS_DIAG, 32'h0000_FFFF, 32'h0000_0702, 2'h0);
    fchk(1'b1);
  endtask

  // open sensor: threshold itself stays, one count above falls back
  task automatic t_open();
    do_reset();
    ctrl(8'h03);
    chk("gain", {24'h00_0000, gain}, {28'h000_0001, avs_pkg::AVS_GAIN_TEMP});
    samp(16'h0100, 16'h0000, 16'h00A4);
    chk("ai_mode", {28'h000_0000, ai_mode}, 32'h0000_0003);
    samp(16'h0100, 16'h0000, 16'h00A5);
    chk("ai_mode", {28'h000_0000, ai_mode}, 32'h0000_0000);
    chk("gain", {24'h00_0000, gain}, 32'h0000_0011);
    rchk(avs_pkg::AVS_OFS_STAT, 32'h0000_FFFF, 32'h0000_8100, 2'h0);
    rchk(avs_pkg::AVS_OFS_DIAG, 32'h0000_FFFF, 32'h0000_0602, 2'h0);
    fchk(1'b1);
  endtask

  task automatic t_bad();
    do_reset();
    ctrl(8'h30);
    chk("ao_mode", {28'h000_0000, ao_mode}, 32'h0000_0000);
    rchk(avs_pkg::AVS_OFS_DIAG, 32'h0000_FFFF, 32'h0000_0302, 2'h0);
    fchk(1'b1);
  endtask

  task automatic t_map();
    rchk(8'h1C, '1, 32'h0000_0000, 2'h2);
    wchk(avs_pkg::AVS_OFS_STAT, 32'h0000_00FF, 4'hF, 2'h2);
    wchk(8'h1C, 32'h0000_00FF, 4'hF, 2'h2);
    rchk(avs_pkg::AVS_OFS_CTRL, 32'h0000_01FF, 32'h0000_0130, 2'h0);
  endtask

  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence; fault scenarios from t_ao on start with a reset so each starts clean, t_neg runs straight after t_ai
  initial begin
    rst_i = 1'b1;
    {smp, sense, smp_v} = '0;
    fails = 0;
    samples_checked = 0;
    do_reset();
    t_reset();
    t_ai();
    t_neg();
    t_ao();
    t_ai_ovf();
    t_open();
    t_bad();
    t_map();
    print_verdict();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    print_verdict();
  end
endmodule // testbench
